// *** core/cirp_defines.vh ***
`ifndef CIRP_DEFINES_VH
`define CIRP_DEFINES_VH
`define CIRP_OFS_STATUS_DMA 8'hD8
`define CIRP_OFS_CMD_INT 8'hD9
`define CIRP_OFS_DATA_PORT 8'hDA
`define CIRP_OFS_ADDR_PTR 8'hDB
`define CIRP_BIT_BASE_STATUS 8'hD8
`define CIRP_BIT_TOP_STATUS 8'hDF
`define CIRP_PTR_RESET 8'h64
`define CIRP_PTR_DMA_BIT 7
`define CIRP_PTR_RSVD_BIT 6
`define CIRP_PTR_AINC_BIT 5
`define CIRP_SEL_W 5
`define CIRP_INT_PAD 3'h7
`define CIRP_RSVD_READ 1'h1
`define CIRP_PTR_TOP 5'h1F
`define CIRP_DMA_RAM_RESET 8'h00
`endif

// *** core/cirp_regfile.v ***
`timescale 1ns/1ps
// Internal register store of the controller, registered read port
module cirp_regfile (
  input wire clk,
  input wire rst_n,
  input wire [4:0] rd_addr,
  output reg [7:0] rd_data_ff,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [7:0] wr_data
);
  reg [7:0] mem_ff [0:31];
  integer i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
      for (i = 0; i < 32; i = i + 1) begin
        mem_ff[i] <= 8'h00;
      end
    end else begin
      rd_data_ff <= mem_ff[rd_addr];
      if (wr_en) begin
        mem_ff[wr_addr] <= wr_data;
      end
    end
  end
endmodule

// *** core/cirp_port.v ***
`timescale 1ns/1ps
`include "cirp_defines.vh"
module cirp_port (
  input wire clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire sfr_rd,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_bit_wr,
  input wire [7:0] sfr_bit_addr,
  input wire sfr_bit_val,
  output reg [7:0] sfr_rdata_ff,
  output reg sfr_rvalid_ff,
  input wire [4:0] int_flags,
  input wire [7:0] status_bits,
  output reg [7:0] command_ff,
  output reg command_strobe_ff,
  output reg [7:0] dma_ram_address_ff,
  output reg dma_start_ff,
  output reg [4:0] dma_buffer_select_ff,
  input wire dma_done,
  output reg [7:0] pointer_ff
);
  reg [7:0] nxt_pointer;
  reg [7:0] nxt_rdata;
  reg [1:0] rd_pend_ff;
  wire dat_rd;
  wire dat_wr;
  wire [7:0] port_data;
  wire [7:0] ptr_view;
  wire [7:0] status_after_bit;

  function hit;
    input [7:0] a;
    input [7:0] want;
    begin
      hit = (a == want);
    end
  endfunction

  assign dat_rd = sfr_rd & hit(sfr_addr, `CIRP_OFS_DATA_PORT);
  assign dat_wr = sfr_wr & hit(sfr_addr, `CIRP_OFS_DATA_PORT);
  assign ptr_view = {pointer_ff[7], `CIRP_RSVD_READ, pointer_ff[5:0]};

  cirp_regfile u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .rd_addr(pointer_ff[4:0]),
    .rd_data_ff(port_data),
    .wr_en(dat_wr),
    .wr_addr(pointer_ff[4:0]),
    .wr_data(sfr_wdata)
  );

  // Bit write merges into the stored DMA address, not the live status
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bitw
      localparam [7:0] BIT_ADDR = `CIRP_BIT_BASE_STATUS + g;
      assign status_after_bit[g] =
        (sfr_bit_addr == BIT_ADDR) ?
        sfr_bit_val : dma_ram_address_ff[g];
    end
  endgenerate

  always @* begin
    nxt_pointer = pointer_ff;
    if (sfr_wr && hit(sfr_addr, `CIRP_OFS_ADDR_PTR)) begin
      nxt_pointer = sfr_wdata;
      // Reserved bit keeps its reset value of 1 from 64H; the other bits take the written data
      nxt_pointer[`CIRP_PTR_RSVD_BIT] = `CIRP_RSVD_READ;
    end else if ((dat_rd || dat_wr) && pointer_ff[`CIRP_PTR_AINC_BIT]) begin
      // Wrap past the top register drops auto increment
      if (pointer_ff[4:0] == `CIRP_PTR_TOP) begin
        nxt_pointer[4:0] = 5'h00;
        nxt_pointer[`CIRP_PTR_AINC_BIT] = 1'b0;
      end else begin
        nxt_pointer[4:0] = pointer_ff[4:0] + 5'h01;
      end
    end
    if (dma_done) begin
      nxt_pointer[`CIRP_PTR_DMA_BIT] = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pointer_ff <= `CIRP_PTR_RESET;
    end else begin
      pointer_ff <= nxt_pointer;
    end
  end

  // Start pulse on a pointer write that sets the DMA bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_start_ff <= 1'b0;
      dma_buffer_select_ff <= 5'h00;
    end else begin
      dma_start_ff <= sfr_wr & hit(sfr_addr, `CIRP_OFS_ADDR_PTR) &
        sfr_wdata[`CIRP_PTR_DMA_BIT];
      if (sfr_wr && hit(sfr_addr, `CIRP_OFS_ADDR_PTR)) begin
        dma_buffer_select_ff <= sfr_wdata[4:0];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      command_ff <= 8'h00;
      command_strobe_ff <= 1'b0;
      dma_ram_address_ff <= `CIRP_DMA_RAM_RESET;
    end else begin
      command_strobe_ff <= sfr_wr & hit(sfr_addr, `CIRP_OFS_CMD_INT);
      if (sfr_wr && hit(sfr_addr, `CIRP_OFS_CMD_INT)) begin
        command_ff <= sfr_wdata;
      end
      if (sfr_wr && hit(sfr_addr, `CIRP_OFS_STATUS_DMA)) begin
        dma_ram_address_ff <= sfr_wdata;
      end else if (sfr_bit_wr) begin
        dma_ram_address_ff <= status_after_bit;
      end
    end
  end

  // Non-port reads answer one cycle after the strobe
  always @* begin
    nxt_rdata = 8'h00;
    case (sfr_addr)
      `CIRP_OFS_ADDR_PTR: nxt_rdata = ptr_view;
      `CIRP_OFS_CMD_INT: nxt_rdata = {`CIRP_INT_PAD, int_flags};
      `CIRP_OFS_STATUS_DMA: nxt_rdata = status_bits;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Data port reads take two cycles: memory read is registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_ff <= 2'b00;
      sfr_rdata_ff <= 8'h00;
      sfr_rvalid_ff <= 1'b0;
    end else begin
      rd_pend_ff <= {rd_pend_ff[0], dat_rd};
      if (rd_pend_ff[0]) begin
        sfr_rdata_ff <= port_data;
        sfr_rvalid_ff <= 1'b1;
      end else if (sfr_rd && !dat_rd) begin
        sfr_rdata_ff <= nxt_rdata;
        sfr_rvalid_ff <= 1'b1;
      end else begin
        sfr_rvalid_ff <= 1'b0;
      end
    end
  end
endmodule

// *** sim/cirp_port_checker.sv ***
`timescale 1ns/1ps
module cirp_port_checker (
  input wire clk, input wire rst_n, input wire [7:0] sfr_addr,
  input wire sfr_rd, input wire sfr_wr, input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_ff, input wire sfr_rvalid_ff,
  input wire [7:0] status_bits, input wire [7:0] command_ff,
  input wire command_strobe_ff, input wire [7:0] dma_ram_address_ff,
  input wire dma_done, input wire [7:0] pointer_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rsv_fixed_a: assert property (pointer_ff[6]) else $error("bit6");
  sta_read_a: assert property (sfr_rd && sfr_addr == 8'hD8 |=>
    sfr_rdata_ff == $past(status_bits)) else $error("status");
  ptr_read_a: assert property (sfr_rd && sfr_addr == 8'hDB |=>
    sfr_rvalid_ff && sfr_rdata_ff == $past(pointer_ff)) else $error("ptr");
  cmd_write_a: assert property (sfr_wr && sfr_addr == 8'hD9 |=>
    command_strobe_ff && command_ff == $past(sfr_wdata)) else $error("cmd");
  dma_addr_a: assert property (sfr_wr && sfr_addr == 8'hD8 |=>
    dma_ram_address_ff == $past(sfr_wdata)) else $error("ram");
  dma_clear_a: assert property (dma_done |=> !pointer_ff[7])
    else $error("dma");
  auto_inc_a: assert property ((sfr_rd || sfr_wr) && sfr_addr == 8'hDA
    && pointer_ff[5] |=> pointer_ff[4:0] == $past(pointer_ff[4:0]) + 5'h01)
    else $error("inc");
  data_lat_a: assert property (sfr_rd && sfr_addr == 8'hDA |-> ##2
    sfr_rvalid_ff) else $error("lat");
  cover property (dma_done);
  cover property (sfr_rd && sfr_addr == 8'hDA);
  cover property (sfr_wr && sfr_addr == 8'hD9);
endmodule
bind cirp_port cirp_port_checker u_chk (.*);

// *** sim/cirp_ctrl_model.sv ***
`timescale 1ns/1ps
// Flags and status follow the last command so reads are predictable
module cirp_ctrl_model (
  input wire clk, input wire rst_n, input wire [7:0] cmd,
  input wire start, output reg [4:0] flags_ff, output reg [7:0] stat_ff,
  output wire done
);
  reg [2:0] dly_ff;
  assign done = dly_ff[2];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= 5'h00;
      stat_ff <= 8'h00;
      dly_ff <= 3'h0;
    end else begin
      flags_ff <= cmd[4:0] ^ 5'h15;
      stat_ff <= {cmd[3:0], cmd[7:4]};
      dly_ff <= {dly_ff[1:0], start};
    end
  end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg [7:0] sfr_wdata = 8'h00;
  reg [7:0] sfr_bit_addr = 8'h00;
  reg sfr_rd = 1'b0, sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
  wire [7:0] rdata, cmd, stat, ram, ptr;
  wire [4:0] flags;
  wire rvalid, start, done;
  integer errors = 0;
  integer check_count = 0;
  integer k;
  cirp_port u_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_val(sfr_bit_val), .sfr_rdata_ff(rdata),
    .sfr_rvalid_ff(rvalid), .int_flags(flags), .status_bits(stat),
    .command_ff(cmd), .command_strobe_ff(), .dma_ram_address_ff(ram),
    .dma_start_ff(start), .dma_buffer_select_ff(), .dma_done(done),
    .pointer_ff(ptr));
  cirp_ctrl_model u_ctrl (.clk(clk), .rst_n(rst_n), .cmd(cmd),
    .start(start), .flags_ff(flags), .stat_ff(stat), .done(done));
  initial begin
    forever #20 clk = ~clk;
  end
  task end_sim;
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task c(input [7:0] g, input [7:0] e);
    check_count = check_count + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("unexpected %0t got %h exp %h", $time, g, e);
    end
  endtask
  task w(input [7:0] a, input [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task r(input [7:0] a, input [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(negedge clk);
    k = 0;
    while (rvalid !== 1'b1 && k < 4) begin
      @(negedge clk);
      k = k + 1;
    end
    c(rdata, e);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    r(8'hDB, 8'h64);
    w(8'hDB, 8'h05);
    r(8'hDB, 8'h45);
    w(8'hDB, 8'h3E);
    w(8'hDA, 8'h11);
    w(8'hDA, 8'h22);
    r(8'hDB, 8'h40);
    w(8'hDB, 8'h1F);
    r(8'hDA, 8'h22);
    w(8'hD9, 8'hC3);
    r(8'hD9, 8'hF6);
    c(cmd, 8'hC3);
    w(8'hD8, 8'h5A);
    r(8'hD8, 8'h3C);
    @(posedge clk);
    sfr_bit_addr <= 8'hDF;
    sfr_bit_val <= 1'b1;
    sfr_bit_wr <= 1'b1;
    @(posedge clk);
    sfr_bit_wr <= 1'b0;
    @(negedge clk);
    c(ram, 8'hDA);
    w(8'hDB, 8'h8A);
    repeat (6) @(posedge clk);
    r(8'hDB, 8'h4A);
    r(8'h80, 8'h00);
    end_sim;
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors = errors + 1;
    end_sim;
  end
endmodule
